/* File: shared/capture_map.vh */
// Register offsets, field positions and reset values of the event capture block.
// Included by the capture pair and capture block design files, not by the synchroniser; holds definitions only.
`ifndef CAPTURE_MAP_VH
`define CAPTURE_MAP_VH
`define CAP_ONE_LOW_OFFSET   7'h60
`define CAP_ONE_HIGH_OFFSET  7'h64
`define CAP_TWO_LOW_OFFSET   7'h68
`define CAP_TWO_HIGH_OFFSET  7'h6C
`define CAP_RESET_VALUE      32'h00000000
`define CAP_ONE_BIT          1
`define CAP_TWO_BIT          2
`define CAP_NUM_DEFAULT      0
`define CAP_NUM_ONE_MIN      2
`define CAP_NUM_TWO_MIN      3
`endif

/* File: hw/event_sync.v */
// Three-stage synchroniser and rising edge detector for one event input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module event_sync (
    input  wire clk,
    input  wire rst,
    input  wire event_in,
    output reg  rise
);
    reg meta_reg;
    reg sync_a_reg;
    reg sync_b_reg;
    reg agreed_reg;

    // A change counts only once the last two stages agree, so one glitchy
    // sample cannot produce a false edge.
    always @(posedge clk) begin
        if (rst) begin
            meta_reg   <= 1'b0;
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
            agreed_reg <= 1'b0;
            rise       <= 1'b0;
        end else begin
            meta_reg   <= event_in;
            sync_a_reg <= meta_reg;
            sync_b_reg <= sync_a_reg;
            rise       <= 1'b0;
            if (sync_a_reg == sync_b_reg) begin
                agreed_reg <= sync_b_reg;
                rise       <= sync_b_reg & ~agreed_reg; // R14
            end
        end
    end
endmodule // event_sync
`default_nettype wire

/* File: hw/capture_pair.v */
// One 64-bit capture register pair loaded from the running time value.
// Assumes time words come from the same clock domain.
`timescale 1ns/1ps
`include "capture_map.vh"
`default_nettype none
module capture_pair (
    input  wire        clk,
    input  wire        rst,
    input  wire        load,
    input  wire [31:0] time_low_word,
    input  wire [31:0] time_high_word,
    output reg  [31:0] low_word,
    output reg  [31:0] high_word
);
    // Both halves load on the same edge from one counter value.
    always @(posedge clk) begin
        if (rst) begin
            low_word  <= `CAP_RESET_VALUE;
            high_word <= `CAP_RESET_VALUE;
        end else if (load) begin
            low_word  <= time_low_word;  // R15
            high_word <= time_high_word; // R15
        end
    end
endmodule // capture_pair
`default_nettype wire

/* File: hw/rtc_event_capture_latches.v */
// Time capture for event inputs one and two with raw flags and interrupt.
// Assumes the time words, enables and flag clear come from logic on clk.
//
// Contract
// R01 - Input-one capture registers exist only when the capture count is two or more.
// R02 - Input-two capture registers exist only when the capture count is three.
// R03 - An enabled rising edge on input one copies the low time word into its low register.
// R04 - An enabled rising edge on input one copies the high time word into its high register.
// R05 - An enabled rising edge on input two copies the low time word into its low register.
// R06 - An enabled rising edge on input two copies the high time word into its high register.
// R07 - With input one disabled its capture registers hold their value.
// R08 - With input two disabled its capture registers hold their value.
// R09 - Every rising edge on input one sets its sticky raw flag; the code sets it only when input one is present (capture count two or more).
// R10 - Every rising edge on input two sets its sticky raw flag; the code sets it only when input two is present (capture count three).
// R11 - The interrupt asserts when the input-one flag and its enable are both set.
// R12 - The interrupt asserts when the input-two flag and its enable are both set.
// R13 - The capture count is a parameter from zero to three, default zero.
// R14 - Each event input is synchronised and a rising edge is low then high.
// R15 - Both words of a pair come from one counter value and bus writes do not touch them.
`timescale 1ns/1ps
`include "capture_map.vh"
`default_nettype none
module rtc_event_capture_latches #(
    parameter CAPTURE_NUM = `CAP_NUM_DEFAULT // R13
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        event_in_one,
    input  wire        event_in_two,
    input  wire [31:0] time_low_word,
    input  wire [31:0] time_high_word,
    input  wire        capture_one_enable,
    input  wire        capture_two_enable,
    input  wire        capture_one_irq_enable,
    input  wire        capture_two_irq_enable,
    input  wire [2:0]  flag_clear,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [6:0]  paddr,
    output reg  [31:0] prdata,
    output reg  [2:0]  raw_event_flags,
    output reg         irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Index zero stands for the capture input kept outside this block; it is
    // tied off so the per-channel loops stay uniform.
    localparam CHANNELS = 3;
    localparam WORD     = 32;

    wire [CHANNELS-1:1]      event_pin;
    wire [CHANNELS-1:1]      enabled;
    wire [CHANNELS-1:1]      load;
    wire [CHANNELS-1:0]      present;
    wire [CHANNELS-1:0]      rise;
    wire [CHANNELS-1:0]      flags_next;
    wire [CHANNELS-1:0]      low_hit;
    wire [CHANNELS-1:0]      high_hit;
    wire [WORD*CHANNELS-1:0] captured_low;
    wire [WORD*CHANNELS-1:0] captured_high;
    wire [WORD*CHANNELS-1:0] channel_read;
    wire                     read_setup;
    wire                     write_setup;
    reg                      irq_next;
    reg  [WORD-1:0]          read_next;
    reg  [WORD-1:0]          prdata_next;

    ////////////////////////////////////////////////////////////////////////////
    assign event_pin[1] = event_in_one;
    assign event_pin[2] = event_in_two;

    assign present[0] = 1'b0;
    assign present[1] = (CAPTURE_NUM >= `CAP_NUM_ONE_MIN); // R01
    assign present[2] = (CAPTURE_NUM == `CAP_NUM_TWO_MIN); // R02

    // A disabled channel never loads, so its pair keeps its value.
    assign enabled[1] = capture_one_enable; // R07
    assign enabled[2] = capture_two_enable; // R08

    assign low_hit[0]  = 1'b0;
    assign low_hit[1]  = (paddr == `CAP_ONE_LOW_OFFSET);
    assign low_hit[2]  = (paddr == `CAP_TWO_LOW_OFFSET);

    assign high_hit[0] = 1'b0;
    assign high_hit[1] = (paddr == `CAP_ONE_HIGH_OFFSET);
    assign high_hit[2] = (paddr == `CAP_TWO_HIGH_OFFSET);

    assign rise[0]                 = 1'b0;
    assign captured_low[WORD-1:0]  = `CAP_RESET_VALUE;
    assign captured_high[WORD-1:0] = `CAP_RESET_VALUE;

    ////////////////////////////////////////////////////////////////////////////
    // One synchroniser and one capture pair per channel. The pair of an absent
    // channel is still built but never loads and never reads back.
    genvar ch;
    generate
        for (ch = 1; ch < CHANNELS; ch = ch + 1) begin : channel
            event_sync sync (
                .clk      (clk),
                .rst      (rst),
                .event_in (event_pin[ch]),
                .rise     (rise[ch])
            );

            assign load[ch] = present[ch] & rise[ch] & enabled[ch]; // R03 R04 R05 R06

            capture_pair pair (
                .clk            (clk),
                .rst            (rst),
                .load           (load[ch]),
                .time_low_word  (time_low_word),
                .time_high_word (time_high_word),
                .low_word       (captured_low[WORD*ch +: WORD]),
                .high_word      (captured_high[WORD*ch +: WORD])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // An edge in the same cycle as a clear keeps the flag set, so a new event
    // is never lost to a clear aimed at an older one.
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : per_bit
            assign flags_next[ch] = (present[ch] & rise[ch]) // R09 R10
                                  | (raw_event_flags[ch] & ~flag_clear[ch]);

            assign channel_read[WORD*ch +: WORD] =
                (present[ch] & low_hit[ch])  ? captured_low[WORD*ch +: WORD]  :
                (present[ch] & high_hit[ch]) ? captured_high[WORD*ch +: WORD] :
                `CAP_RESET_VALUE;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // At most one channel matches an address, so the words are simply merged.
    always @* begin
        read_next = channel_read[WORD*0 +: WORD]
                  | channel_read[WORD*1 +: WORD]
                  | channel_read[WORD*2 +: WORD];
    end

    // The word is taken in the setup phase and held through the access phase,
    // so the master samples a stable value. Writes select nothing, which keeps
    // the capture registers read-only.
    assign read_setup  = psel & ~penable & ~pwrite;
    assign write_setup = psel & ~penable & pwrite;

    always @* begin
        prdata_next = prdata;
        if (!psel) begin
            prdata_next = `CAP_RESET_VALUE;
        end else if (read_setup) begin
            prdata_next = read_next;
        end else if (write_setup) begin
            prdata_next = `CAP_RESET_VALUE; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The interrupt follows the next flag value, so it rises with its flag.
    always @* begin
        irq_next = 1'b0;
        if (flags_next[`CAP_ONE_BIT] && capture_one_irq_enable) begin
            irq_next = 1'b1; // R11
        end
        if (flags_next[`CAP_TWO_BIT] && capture_two_irq_enable) begin
            irq_next = 1'b1; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (rst) begin
            raw_event_flags <= 3'h0;
        end else begin
            raw_event_flags <= flags_next;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_next;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prdata <= `CAP_RESET_VALUE;
        end else begin
            prdata <= prdata_next;
        end
    end
endmodule // rtc_event_capture_latches
`default_nettype wire

/* File: verification/event_source.sv */
// Far side model: running time value and two event pins.
// Assumes pin requests come from the bench just after clk edges.
`timescale 1ns/1ps
`default_nettype none
module event_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] pin_req,
    output logic            event_in_one = 1'b0,
    output logic            event_in_two = 1'b0,
    output logic [31:0]     time_low_word = 32'h0,
    output logic [31:0]     time_high_word = 32'hFFFFFFFF
);
    // Pins lag the request by 7 ns so they never move on a sampling edge.
    always @(pin_req) {event_in_two, event_in_one} <= #7 pin_req;
    // High word is the inverse of the low word, so a torn capture shows.
    always @(posedge clk) begin
        time_low_word  <= rst ? 32'h0 : time_low_word + 32'h1;
        time_high_word <= rst ? 32'hFFFFFFFF : ~(time_low_word + 32'h1);
    end
endmodule // event_source
`default_nettype wire

/* File: verification/capture_checker_properties.sv */
// Port checks on the event capture block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module capture_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        event_in_one,
    input wire logic        event_in_two,
    input wire logic        capture_one_irq_enable,
    input wire logic        capture_two_irq_enable,
    input wire logic [2:0]  flag_clear,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [6:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic [2:0]  raw_event_flags,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_one_flag_keep: assert property (raw_event_flags[1] && !flag_clear[1] |=> raw_event_flags[1])
        else $error("flag one dropped");
    a_two_flag_keep: assert property (raw_event_flags[2] && !flag_clear[2] |=> raw_event_flags[2])
        else $error("flag two dropped");
    a_one_pin_sets: assert property ($rose(event_in_one) ##1 (event_in_one && !flag_clear[1])[*6]
        |-> raw_event_flags[1]) else $error("flag one not set");
    a_two_pin_sets: assert property ($rose(event_in_two) ##1 (event_in_two && !flag_clear[2])[*6]
        |-> raw_event_flags[2]) else $error("flag two not set");
    a_one_irq_on: assert property (raw_event_flags[1] && capture_one_irq_enable && !flag_clear[1]
        ##1 capture_one_irq_enable |-> irq) else $error("irq one missing");
    a_two_irq_on: assert property (raw_event_flags[2] && capture_two_irq_enable && !flag_clear[2]
        ##1 capture_two_irq_enable |-> irq) else $error("irq two missing");
    a_prdata_quiet: assert property (!(psel && !pwrite) |=> prdata == 32'h0)
        else $error("read data without read");
    a_unmapped_zero: assert property (psel && paddr == 7'h70 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_access_hold: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved in access phase");
endmodule // capture_checker
`default_nettype wire

/* File: verification/rtc_event_capture_latches_tb.sv */
// Bench for the event capture block with the capture count set to three, so inputs one and two are built in.
// Assumes the design and the event source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module rtc_event_capture_latches_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  pin_req = 2'h0;
    logic [3:0]  en = 4'h0;
    logic [2:0]  flag_clear = 3'h0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [6:0]  paddr = 7'h00;
    wire  [31:0] prdata, tlo, thi;
    wire  [2:0]  raw_event_flags;
    wire         irq, ev1, ev2;
    logic [31:0] d, lo, t0, k;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #12.5 clk = ~clk;
    event_source u_src (.clk(clk), .rst(rst), .pin_req(pin_req), .event_in_one(ev1),
        .event_in_two(ev2), .time_low_word(tlo), .time_high_word(thi));
    rtc_event_capture_latches #(.CAPTURE_NUM(3)) u_dut (.clk(clk), .rst(rst),
        .event_in_one(ev1), .event_in_two(ev2), .time_low_word(tlo), .time_high_word(thi),
        .capture_one_enable(en[0]), .capture_two_enable(en[1]), .capture_one_irq_enable(en[2]),
        .capture_two_irq_enable(en[3]), .flag_clear(flag_clear), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .raw_event_flags(raw_event_flags), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // The idle cycle after each access keeps psel from moving twice in one step.
    task automatic rd(input logic [6:0] a, input logic wr);
        psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = a;
        tick(1);
        penable = 1'b1;
        tick(1);
        d = prdata;
        psel = 1'b0;
        penable = 1'b0;
        tick(1);
    endtask
    task automatic fire(input int i);
        t0 = tlo;
        pin_req[i] = 1'b1;
        tick(8);
        pin_req[i] = 1'b0;
        tick(8);
    endtask
    task automatic cap(input logic [6:0] a);
        rd(a, 1'b0);
        lo = d;
        rd(a + 7'h04, 1'b0);
        chk(d, ~lo);
        chk(lo - t0 < 32'hC, 32'h1);
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        tick(16);
        rst = 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(7'h60 + 7'(a * 4), 1'b0);
            chk(d, 32'h0);
        end
        en = 4'h5;
        fire(0);
        cap(7'h60);
        k = lo;
        chk(raw_event_flags, 3'h2);
        chk(irq, 1'b1);
        fire(1);
        chk(raw_event_flags, 3'h6);
        rd(7'h68, 1'b0);
        chk(d, 32'h0);
        flag_clear = 3'h2;
        tick(1);
        flag_clear = 3'h0;
        tick(2);
        chk(irq, 1'b0);
        en = 4'hA;
        tick(2);
        chk(irq, 1'b1);
        fire(1);
        cap(7'h68);
        fire(0);
        chk(raw_event_flags, 3'h6);
        rd(7'h60, 1'b1);
        rd(7'h60, 1'b0);
        chk(d, k);
        rd(7'h70, 1'b0);
        chk(d, 32'h0);
        tally_and_finish;
    end
endmodule // rtc_event_capture_latches_tb
bind rtc_event_capture_latches capture_checker u_chk (.clk(clk), .rst(rst),
    .event_in_one(event_in_one), .event_in_two(event_in_two), .flag_clear(flag_clear),
    .capture_one_irq_enable(capture_one_irq_enable), .capture_two_irq_enable(capture_two_irq_enable),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .raw_event_flags(raw_event_flags), .irq(irq));
`default_nettype wire
